// *** hw/cpr_pkg.sv ***
/*
 * cpr_pkg: register map, field layout, reset values and decode constants
 * for the charge parameter register bank.
 * assumes: byte-wide registers, one system clock, no other users of the map.
 */
package cpr_pkg;

	// register offsets
	localparam logic [7:0] CHARGE_CURRENT_LIMIT_OFS          = 8'h02;
	localparam logic [7:0] PRECHARGE_TERMINATION_CURRENT_OFS = 8'h03;
	localparam logic [7:0] BATTERY_VOLTAGE_LIMIT_OFS         = 8'h04;

	// reset values
	localparam logic [7:0] CHARGE_CURRENT_LIMIT_RST          = 8'h91;
	localparam logic [7:0] PRECHARGE_TERMINATION_CURRENT_RST = 8'h12;
	localparam logic [7:0] BATTERY_VOLTAGE_LIMIT_RST         = 8'h40;

	// field positions
	localparam int RESERVED_BIT             = 7;
	localparam int INPUT_FET_FULL_ON_BIT    = 6;
	localparam int FAST_CHARGE_CURRENT_LSB  = 0;
	localparam int PRECHARGE_CURRENT_LSB    = 4;
	localparam int TERMINATION_CURRENT_LSB  = 0;
	localparam int BATTERY_REG_VOLTAGE_LSB  = 3;
	localparam int TOPOFF_DURATION_LSB      = 1;
	localparam int RECHARGE_THRESHOLD_BIT   = 0;

	// fast-charge current decode
	localparam logic [10:0] FAST_CHARGE_STEP_MA   = 11'h014;
	localparam logic [5:0]  FAST_CHARGE_LINEAR_TOP = 6'h3b;
	localparam logic [10:0] FAST_CHARGE_3C_MA     = 11'h50a;
	localparam logic [10:0] FAST_CHARGE_3D_MA     = 11'h550;
	localparam logic [10:0] FAST_CHARGE_3E_MA     = 11'h596;
	localparam logic [10:0] FAST_CHARGE_3F_MA     = 11'h5dc;

	// pre-charge / termination decode: offset and step 20 ma, clamp at code 12
	localparam logic [8:0] LOW_CURRENT_OFFSET_MA = 9'h014;
	localparam logic [8:0] LOW_CURRENT_STEP_MA   = 9'h014;
	localparam logic [3:0] LOW_CURRENT_CLAMP     = 4'hc;

	// battery regulation voltage decode
	localparam logic [4:0]  VREG_TABLE_TOP   = 5'h08;
	localparam logic [12:0] VREG_LINEAR_BASE = 13'h10cc;
	localparam logic [12:0] VREG_STEP_MV     = 13'h000a;

	// recharge threshold
	localparam logic [7:0] RECHARGE_LOW_MV  = 8'h78;
	localparam logic [7:0] RECHARGE_HIGH_MV = 8'hd2;

	// top-off durations in minutes, and input-fet limit (input limit code < 6)
	localparam logic [5:0] TOPOFF_STEP_MIN      = 6'h0f;
	localparam logic [4:0] FET_FULL_LIMIT_CODE  = 5'h06;

endpackage : cpr_pkg

// *** hw/cpr_dec_if.sv ***
/*
 * cpr_dec_if: carries next-state register codes to the decoders and decoded values back.
 * assumes: purely combinational decoders on the far side.
 */
`timescale 1ns/1ps
interface cpr_dec_if;
	logic [5:0]  fast_charge_current_code;
	logic [10:0] fast_charge_current_ma;
	logic [4:0]  vreg_code;
	logic [12:0] vreg_mv;

	modport owner    (output fast_charge_current_code, output vreg_code, input fast_charge_current_ma, input vreg_mv);
	modport fast_charge_current_dec (input fast_charge_current_code, output fast_charge_current_ma);
	modport vreg_dec (input vreg_code, output vreg_mv);
endinterface : cpr_dec_if

// *** hw/cpr_fast_charge_current_decode.sv ***
/*
 * cpr_fast_charge_current_decode: fast-charge current code to milliamps.
 * assumes: combinational; the owner registers the result.
 */
`timescale 1ns/1ps
module cpr_fast_charge_current_decode (
	cpr_dec_if.fast_charge_current_dec dec
);
	logic [10:0] linear_ma;

	always_comb begin
		linear_ma = 11'(dec.fast_charge_current_code) * cpr_pkg::FAST_CHARGE_STEP_MA;
		case (dec.fast_charge_current_code)
			6'h3c:   dec.fast_charge_current_ma = cpr_pkg::FAST_CHARGE_3C_MA;
			6'h3d:   dec.fast_charge_current_ma = cpr_pkg::FAST_CHARGE_3D_MA;
			6'h3e:   dec.fast_charge_current_ma = cpr_pkg::FAST_CHARGE_3E_MA;
			6'h3f:   dec.fast_charge_current_ma = cpr_pkg::FAST_CHARGE_3F_MA;
			default: dec.fast_charge_current_ma = linear_ma;
		endcase
	end
endmodule : cpr_fast_charge_current_decode

// *** hw/cpr_vreg_decode.sv ***
/*
 * cpr_vreg_decode: battery regulation voltage code to millivolts.
 * assumes: combinational; the owner registers the result.
 */
`timescale 1ns/1ps
module cpr_vreg_decode (
	cpr_dec_if.vreg_dec dec
);
	logic [12:0] steps;

	always_comb begin
		steps = 13'(dec.vreg_code - (cpr_pkg::VREG_TABLE_TOP + 5'h01));
		case (dec.vreg_code)
			5'h00:   dec.vreg_mv = 13'h0db0;
			5'h01:   dec.vreg_mv = 13'h0e10;
			5'h02:   dec.vreg_mv = 13'h0e70;
			5'h03:   dec.vreg_mv = 13'h0ed8;
			5'h04:   dec.vreg_mv = 13'h0f40;
			5'h05:   dec.vreg_mv = 13'h0fa0;
			5'h06:   dec.vreg_mv = 13'h1004;
			5'h07:   dec.vreg_mv = 13'h1036;
			5'h08:   dec.vreg_mv = 13'h1068;
			default: dec.vreg_mv = 13'(cpr_pkg::VREG_LINEAR_BASE
				+ steps * cpr_pkg::VREG_STEP_MV);
		endcase
	end
endmodule : cpr_vreg_decode

// *** hw/cpr_charge_param_regs.sv ***
/*
 * cpr_charge_param_regs: three byte-wide charge parameter registers with
 * their decoded settings, driven to the analog charge control.
 * assumes: the serial-bus engine presents single-cycle byte read/write
 * strobes; register-defaults and watchdog expiry arrive as one-cycle pulses.
 */
`timescale 1ns/1ps
module cpr_charge_param_regs (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_defaults,
	input  wire logic        i_wdog_expired,
	input  wire logic        i_ce_b,
	input  wire logic        i_charge_enable_bit,
	input  wire logic        i_buck_mode,
	input  wire logic [4:0]  i_input_current_limit,
	output logic      [7:0]  o_reg_rdata,
	output logic             o_reg_ack,
	output logic      [10:0] o_fast_charge_current_ma,
	output logic             o_buck_charge_en,
	output logic             o_input_fet_full_on,
	output logic      [8:0]  o_precharge_current_ma,
	output logic      [8:0]  o_termination_current_ma,
	output logic      [12:0] o_battery_regulation_mv,
	output logic             o_topoff_en,
	output logic      [5:0]  o_topoff_duration_min,
	output logic      [7:0]  o_recharge_threshold_mv
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// shared by pre-charge and termination fields
	function automatic logic [8:0] cpr_low_current_ma(input logic [3:0] code);
		logic [3:0] eff;
		eff = (code > cpr_pkg::LOW_CURRENT_CLAMP) ? cpr_pkg::LOW_CURRENT_CLAMP : code;
		return 9'(cpr_pkg::LOW_CURRENT_OFFSET_MA + 9'(eff) * cpr_pkg::LOW_CURRENT_STEP_MA);
	endfunction : cpr_low_current_ma

	function automatic logic cpr_addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction : cpr_addr_hit

	////////////////////////////////////////////////////////////////////////////
	// register storage

	logic [7:0] charge_current_limit;
	logic [7:0] precharge_termination_current;
	logic [7:0] battery_voltage_limit;
	logic [7:0] next_charge_current_limit;
	logic [7:0] next_precharge_termination_current;
	logic [7:0] next_battery_voltage_limit;

	logic       hit_fast_charge_current;
	logic       hit_termination_current;
	logic       hit_vreg;
	logic       wdog_only;

	always_comb begin
		hit_fast_charge_current  = cpr_addr_hit(i_reg_addr, cpr_pkg::CHARGE_CURRENT_LIMIT_OFS);
		hit_termination_current = cpr_addr_hit(i_reg_addr, cpr_pkg::PRECHARGE_TERMINATION_CURRENT_OFS);
		hit_vreg  = cpr_addr_hit(i_reg_addr, cpr_pkg::BATTERY_VOLTAGE_LIMIT_OFS);
		// watchdog alone leaves the fet bit and the reserved bit alone
		wdog_only = i_wdog_expired && !i_reg_defaults;

		next_charge_current_limit          = charge_current_limit;
		next_precharge_termination_current = precharge_termination_current;
		next_battery_voltage_limit         = battery_voltage_limit;

		// write first, defaults override: a restore must not be undone by a
		// write landing in the same cycle
		if (i_reg_wr && hit_fast_charge_current) begin
			next_charge_current_limit = i_reg_wdata;
		end
		if (i_reg_wr && hit_termination_current) begin
			next_precharge_termination_current = i_reg_wdata;
		end
		if (i_reg_wr && hit_vreg) begin
			next_battery_voltage_limit = i_reg_wdata;
		end

		if (i_reg_defaults) begin
			next_charge_current_limit[6:0] = cpr_pkg::CHARGE_CURRENT_LIMIT_RST[6:0];
		end else if (wdog_only) begin
			next_charge_current_limit[5:0] = cpr_pkg::CHARGE_CURRENT_LIMIT_RST[5:0];
		end
		if (i_reg_defaults || i_wdog_expired) begin
			next_precharge_termination_current = cpr_pkg::PRECHARGE_TERMINATION_CURRENT_RST;
			next_battery_voltage_limit         = cpr_pkg::BATTERY_VOLTAGE_LIMIT_RST;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			charge_current_limit          <= cpr_pkg::CHARGE_CURRENT_LIMIT_RST;
			precharge_termination_current <= cpr_pkg::PRECHARGE_TERMINATION_CURRENT_RST;
			battery_voltage_limit         <= cpr_pkg::BATTERY_VOLTAGE_LIMIT_RST;
		end else begin
			charge_current_limit          <= next_charge_current_limit;
			precharge_termination_current <= next_precharge_termination_current;
			battery_voltage_limit         <= next_battery_voltage_limit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port

	logic [7:0] next_reg_rdata;
	logic       next_reg_ack;

	always_comb begin
		next_reg_ack   = i_reg_rd || i_reg_wr;
		next_reg_rdata = o_reg_rdata;
		if (i_reg_rd) begin
			// unmapped offsets read as zero
			if (hit_fast_charge_current) begin
				next_reg_rdata = charge_current_limit;
			end else if (hit_termination_current) begin
				next_reg_rdata = precharge_termination_current;
			end else if (hit_vreg) begin
				next_reg_rdata = battery_voltage_limit;
			end else begin
				next_reg_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_reg_rdata <= 8'h00;
			o_reg_ack   <= 1'b0;
		end else begin
			o_reg_rdata <= next_reg_rdata;
			o_reg_ack   <= next_reg_ack;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// decoders: fed from next values so outputs move on the write's own edge

	cpr_dec_if dec_bus ();

	assign dec_bus.fast_charge_current_code = next_charge_current_limit[cpr_pkg::FAST_CHARGE_CURRENT_LSB +: 6];
	assign dec_bus.vreg_code = next_battery_voltage_limit[cpr_pkg::BATTERY_REG_VOLTAGE_LSB +: 5];

	cpr_fast_charge_current_decode u_fast_charge_current_decode (
		.dec (dec_bus.fast_charge_current_dec)
	);

	cpr_vreg_decode u_vreg_decode (
		.dec (dec_bus.vreg_dec)
	);

	////////////////////////////////////////////////////////////////////////////
	// charge-control outputs

	logic [10:0] next_fast_charge_current_ma;
	logic        next_buck_charge_en;
	logic        next_input_fet_full_on;
	logic [8:0]  next_precharge_current_ma;
	logic [8:0]  next_termination_current_ma;
	logic [12:0] next_battery_regulation_mv;
	logic        next_topoff_en;
	logic [5:0]  next_topoff_duration_min;
	logic [7:0]  next_recharge_threshold_mv;
	logic [1:0]  topoff_code;
	logic        fast_charge_current_nonzero;
	logic        fet_bit;

	always_comb begin
		topoff_code  = next_battery_voltage_limit[cpr_pkg::TOPOFF_DURATION_LSB +: 2];
		fast_charge_current_nonzero = |dec_bus.fast_charge_current_code;
		fet_bit      = next_charge_current_limit[cpr_pkg::INPUT_FET_FULL_ON_BIT];

		next_fast_charge_current_ma = dec_bus.fast_charge_current_ma;
		// charging needs the pin low, the enable bit and a nonzero current
		next_buck_charge_en = !i_ce_b && i_charge_enable_bit && fast_charge_current_nonzero;

		// the fet choice only matters for low input limits in buck mode
		if (i_buck_mode && (i_input_current_limit < cpr_pkg::FET_FULL_LIMIT_CODE)) begin
			next_input_fet_full_on = fet_bit;
		end else begin
			next_input_fet_full_on = 1'b1;
		end

		next_precharge_current_ma = cpr_low_current_ma(
			next_precharge_termination_current[cpr_pkg::PRECHARGE_CURRENT_LSB +: 4]);
		next_termination_current_ma = cpr_low_current_ma(
			next_precharge_termination_current[cpr_pkg::TERMINATION_CURRENT_LSB +: 4]);

		next_battery_regulation_mv = dec_bus.vreg_mv;

		next_topoff_en           = |topoff_code;
		next_topoff_duration_min = 6'(topoff_code * cpr_pkg::TOPOFF_STEP_MIN);

		if (next_battery_voltage_limit[cpr_pkg::RECHARGE_THRESHOLD_BIT]) begin
			next_recharge_threshold_mv = cpr_pkg::RECHARGE_HIGH_MV;
		end else begin
			next_recharge_threshold_mv = cpr_pkg::RECHARGE_LOW_MV;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			// reset image of the default register contents
			o_fast_charge_current_ma <= 11'h154;
			o_buck_charge_en         <= 1'b0;
			o_input_fet_full_on      <= 1'b1;
			o_precharge_current_ma   <= 9'h028;
			o_termination_current_ma <= 9'h03c;
			o_battery_regulation_mv  <= 13'h1068;
			o_topoff_en              <= 1'b0;
			o_topoff_duration_min    <= 6'h00;
			o_recharge_threshold_mv  <= cpr_pkg::RECHARGE_LOW_MV;
		end else begin
			o_fast_charge_current_ma <= next_fast_charge_current_ma;
			o_buck_charge_en         <= next_buck_charge_en;
			o_input_fet_full_on      <= next_input_fet_full_on;
			o_precharge_current_ma   <= next_precharge_current_ma;
			o_termination_current_ma <= next_termination_current_ma;
			o_battery_regulation_mv  <= next_battery_regulation_mv;
			o_topoff_en              <= next_topoff_en;
			o_topoff_duration_min    <= next_topoff_duration_min;
			o_recharge_threshold_mv  <= next_recharge_threshold_mv;
		end
	end

endmodule : cpr_charge_param_regs

// *** test/cpr_charge_param_regs_checker.sv ***
/*
 * cpr_charge_param_regs_checker: port-level assertions and covers for the
 * charge parameter register bank.
 * assumes: bound to cpr_charge_param_regs; one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module cpr_charge_param_regs_checker (
	input wire logic        i_clk_sys,
	input wire logic        i_rst_b,
	input wire logic        i_reg_wr,
	input wire logic        i_reg_rd,
	input wire logic [7:0]  i_reg_addr,
	input wire logic [7:0]  i_reg_wdata,
	input wire logic        i_reg_defaults,
	input wire logic        i_wdog_expired,
	input wire logic        i_ce_b,
	input wire logic        i_charge_enable_bit,
	input wire logic        i_buck_mode,
	input wire logic [4:0]  i_input_current_limit,
	input wire logic [7:0]  o_reg_rdata,
	input wire logic        o_reg_ack,
	input wire logic [10:0] o_fast_charge_current_ma,
	input wire logic        o_buck_charge_en,
	input wire logic        o_input_fet_full_on,
	input wire logic [8:0]  o_precharge_current_ma,
	input wire logic [8:0]  o_termination_current_ma,
	input wire logic [12:0] o_battery_regulation_mv,
	input wire logic        o_topoff_en,
	input wire logic [5:0]  o_topoff_duration_min,
	input wire logic [7:0]  o_recharge_threshold_mv
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	logic restore;
	assign restore = i_reg_defaults | i_wdog_expired;

	////////////////////////////////////////////////////////////////////////////
	chk_ack_one_cycle: assert property (
		1'b1 |=> o_reg_ack == $past(i_reg_wr | i_reg_rd)) else $error("ack timing wrong");
	chk_rd_unmapped_zero: assert property (
		i_reg_rd && !(i_reg_addr inside {8'h02, 8'h03, 8'h04}) |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_zero_no_charge: assert property (
		o_fast_charge_current_ma == 11'h000 |-> !o_buck_charge_en) else $error("charging at 0 mA");
	chk_buck_en_cause: assert property (
		o_buck_charge_en |-> $past(!i_ce_b && i_charge_enable_bit)) else $error("buck en uncaused");
	chk_fet_forced_on: assert property (
		$past(!i_buck_mode || i_input_current_limit >= 5'h06) |-> o_input_fet_full_on)
		else $error("fet not fully on");
	chk_restore_defaults: assert property (
		restore |=> o_fast_charge_current_ma == 11'h154 && o_precharge_current_ma == 9'h028
		&& o_termination_current_ma == 9'h03c && o_battery_regulation_mv == 13'h1068
		&& !o_topoff_en && o_recharge_threshold_mv == 8'h78) else $error("restore wrong");
	chk_top_fast_code: assert property (
		i_reg_wr && i_reg_addr == 8'h02 && i_reg_wdata[5:0] == 6'h3f && !restore
		|=> o_fast_charge_current_ma == 11'h5dc) else $error("top fast code wrong");
	chk_pre_clamp: assert property (
		i_reg_wr && i_reg_addr == 8'h03 && i_reg_wdata[7:4] > 4'hc && !restore
		|=> o_precharge_current_ma == 9'h104) else $error("precharge not clamped");
	chk_term_clamp: assert property (
		i_reg_wr && i_reg_addr == 8'h03 && i_reg_wdata[3:0] > 4'hc && !restore
		|=> o_termination_current_ma == 9'h104) else $error("term not clamped");
	chk_vreg_span: assert property (
		o_battery_regulation_mv inside {[13'h0db0:13'h11a8]}) else $error("vreg out of range");
	chk_topoff_pair: assert property (
		o_topoff_en == (o_topoff_duration_min != 6'h00)) else $error("topoff en mismatch");

	cov_write: cover property (i_reg_wr ##1 o_reg_ack);
	cov_read: cover property (i_reg_rd ##1 o_reg_ack);
	cov_wdog: cover property (i_wdog_expired);
	cov_defaults: cover property (i_reg_defaults);
endmodule : cpr_charge_param_regs_checker

bind cpr_charge_param_regs cpr_charge_param_regs_checker chk_inst (.i_clk_sys, .i_rst_b,
	.i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_reg_defaults, .i_wdog_expired,
	.i_ce_b, .i_charge_enable_bit, .i_buck_mode, .i_input_current_limit, .o_reg_rdata,
	.o_reg_ack, .o_fast_charge_current_ma, .o_buck_charge_en, .o_input_fet_full_on,
	.o_precharge_current_ma, .o_termination_current_ma, .o_battery_regulation_mv,
	.o_topoff_en, .o_topoff_duration_min, .o_recharge_threshold_mv);

// *** test/cpr_host_model.sv ***
/*
 * cpr_host_model: host side of the byte register port, one-cycle strobes.
 * assumes: caller invokes put just after a rising clock edge.
 */
`timescale 1ns/1ps
module cpr_host_model (
	output logic       o_reg_wr,
	output logic       o_reg_rd,
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata
);
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
	end

	// idle lines invert so a stale value never looks valid
	task automatic put(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
		o_reg_wr = wr;
		o_reg_rd = rd;
		o_reg_addr = (wr | rd) ? a : ~o_reg_addr;
		o_reg_wdata = wr ? d : ~o_reg_wdata;
	endtask : put
endmodule : cpr_host_model

// *** test/testbench.sv ***
/*
 * testbench: drives the register bank and compares against a behavioural model.
 * assumes: ack one cycle after a strobe; outputs registered from next values.
 */
`timescale 1ns/1ps
module testbench;
	logic        i_clk_sys = 1'b0;
	logic        i_rst_b = 1'b0;
	logic        i_reg_wr, i_reg_rd;
	logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_recharge_threshold_mv;
	logic        i_reg_defaults = 1'b0, i_wdog_expired = 1'b0, i_ce_b = 1'b1;
	logic        i_charge_enable_bit = 1'b0, i_buck_mode = 1'b0;
	logic [4:0]  i_input_current_limit = 5'h00;
	logic        o_reg_ack, o_buck_charge_en, o_input_fet_full_on, o_topoff_en;
	logic [10:0] o_fast_charge_current_ma;
	logic [8:0]  o_precharge_current_ma, o_termination_current_ma;
	logic [12:0] o_battery_regulation_mv;
	logic [5:0]  o_topoff_duration_min;
	logic [7:0]  m [2:4];
	int          mismatches = 0, samples_checked = 0;

	always #12.5 i_clk_sys = ~i_clk_sys;

	cpr_host_model cpr_host_model_inst (.o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd),
		.o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
	cpr_charge_param_regs cpr_charge_param_regs_inst (.*);

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	function automatic logic [15:0] low_ma(input logic [3:0] c);
		return 16'(20 + 20 * ((c > 4'hc) ? 12 : int'(c)));
	endfunction : low_ma

	function automatic logic [15:0] vreg_mv(input logic [4:0] c);
		int vt [9] = '{3504, 3600, 3696, 3800, 3904, 4000, 4100, 4150, 4200};
		return (c < 5'h09) ? 16'(vt[c]) : 16'(4300 + 10 * (int'(c) - 9));
	endfunction : vreg_mv

	task automatic cyc(input logic wr, input logic rd, input logic [7:0] a,
			input logic [7:0] d, input logic df, input logic wd);
		logic [7:0] old;
		logic       mapped;
		logic [5:0] fc;
		mapped = (a >= 8'h02) && (a <= 8'h04);
		cpr_host_model_inst.put(wr, rd, a, d);
		i_reg_defaults = df;
		i_wdog_expired = wd;
		i_ce_b = 1'($urandom);
		i_charge_enable_bit = 1'($urandom);
		i_buck_mode = 1'($urandom);
		i_input_current_limit = 5'($urandom);
		@(posedge i_clk_sys);
		#1;
		old = mapped ? m[a] : 8'h00;
		if (wr && mapped) m[a] = d;
		if (df) m[2][6:0] = 7'h11;
		if (wd) m[2][5:0] = 6'h11;
		if (df || wd) begin
			m[3] = 8'h12;
			m[4] = 8'h40;
		end
		fc = m[2][5:0];
		chk(16'(o_reg_ack), 16'(wr | rd));
		if (rd) chk(16'(o_reg_rdata), 16'(old));
		chk(16'(o_fast_charge_current_ma), (fc > 6'h3b) ? 16'(1290 + 70 * (int'(fc) - 60))
			: 16'(20 * int'(fc)));
		chk(16'(o_buck_charge_en), 16'(!i_ce_b && i_charge_enable_bit && fc != 0));
		chk(16'(o_input_fet_full_on), 16'((i_buck_mode && i_input_current_limit < 5'h06)
			? m[2][6] : 1'b1));
		chk(16'(o_precharge_current_ma), low_ma(m[3][7:4]));
		chk(16'(o_termination_current_ma), low_ma(m[3][3:0]));
		chk(16'(o_battery_regulation_mv), vreg_mv(m[4][7:3]));
		chk(16'(o_topoff_en), 16'(m[4][2:1] != 2'b00));
		chk(16'(o_topoff_duration_min), 16'(15 * int'(m[4][2:1])));
		chk(16'(o_recharge_threshold_mv), m[4][0] ? 16'd210 : 16'd120);
	endtask : cyc

	task automatic do_reset();
		cpr_host_model_inst.put(1'b0, 1'b0, 8'h00, 8'h00);
		i_rst_b = 1'b0;
		repeat (2) @(posedge i_clk_sys);
		#1 i_rst_b = 1'b1;
		m = '{8'h91, 8'h12, 8'h40};
		cyc(1'b0, 1'b1, 8'h02, 8'h00, 1'b0, 1'b0);
		chk(16'(o_reg_rdata), 16'h0091);
		cyc(1'b0, 1'b1, 8'h03, 8'h00, 1'b0, 1'b0);
		chk(16'(o_reg_rdata), 16'h0012);
		cyc(1'b0, 1'b1, 8'h04, 8'h00, 1'b0, 1'b0);
		chk(16'(o_reg_rdata), 16'h0040);
	endtask : do_reset

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	initial begin
		#2000000;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(45814));
		do_reset();
		for (int i = 0; i < 256; i++) begin
			cyc(1'b1, 1'b0, 8'h02, 8'(i), 1'b0, 1'b0);
			cyc(1'b1, 1'b0, 8'h03, 8'(i), 1'b0, 1'b0);
			cyc(1'b1, 1'b0, 8'h04, 8'(i), 1'b0, 1'b0);
		end
		// reserved bit survives both restores; read on write returns old byte
		cyc(1'b1, 1'b1, 8'h02, 8'h7f, 1'b0, 1'b0);
		cyc(1'b1, 1'b1, 8'h02, 8'hff, 1'b0, 1'b1);
		cyc(1'b0, 1'b1, 8'h02, 8'h00, 1'b1, 1'b0);
		cyc(1'b1, 1'b0, 8'h01, 8'hff, 1'b0, 1'b0);
		cyc(1'b0, 1'b1, 8'h05, 8'h00, 1'b0, 1'b0);
		repeat (600) cyc(1'($urandom), 1'($urandom), 8'($urandom_range(1, 5)), 8'($urandom),
			$urandom_range(0, 15) == 0, $urandom_range(0, 15) == 0);
		do_reset();
		tally_and_finish();
	end
endmodule : testbench
